//--- logic/pcg_map.vh
`ifndef PCG_MAP_VH
`define PCG_MAP_VH
// Action encodings
`define PCG_ACT_KEEP 2'h0
`define PCG_ACT_TOGGLE 2'h1
`define PCG_ACT_LOW 2'h2
`define PCG_ACT_HIGH 2'h3
// Mode encodings
`define PCG_MODE_DOWN 1'b0
`define PCG_MODE_UPDOWN 1'b1
// Register offsets (word addresses)
`define PCG_REG_CTRL 4'h0
`define PCG_REG_LOAD 4'h1
`define PCG_REG_CMPA 4'h2
`define PCG_REG_CMPB 4'h3
`define PCG_REG_ACTA 4'h4
`define PCG_REG_ACTB 4'h5
`define PCG_REG_OUTCTL 4'h6
`define PCG_REG_COUNT 4'h7
`define PCG_REG_STATUS 4'h8
// Control field positions
`define PCG_CTRL_EN 0
`define PCG_CTRL_MODE 1
// Output control fields
`define PCG_OUT_ENA 0
`define PCG_OUT_ENB 1
`define PCG_OUT_INVA 2
`define PCG_OUT_INVB 3
// Action field positions, two bits each
`define PCG_EV_ZERO 0
`define PCG_EV_LOAD 2
`define PCG_EV_AUP 4
`define PCG_EV_ADN 6
`define PCG_EV_BUP 8
`define PCG_EV_BDN 10
// Reset values
`define PCG_ZERO16 16'h0000
`define PCG_ONE16 16'h0001
`define PCG_ZERO12 12'h000
`define PCG_ZERO32 32'h00000000
`endif

//--- logic/pcg_action.v
`timescale 1ns/100ps
`include "pcg_map.vh"
// ****************************************
// Per-output action resolver
// ****************************************
module pcg_action (
    // Current output level
    input wire cur,
    // Per-event action fields
    input wire [11:0] act,
    // Qualified events
    input wire ev_zero,
    input wire ev_load,
    input wire ev_up,
    input wire ev_dn,
    // Next level
    output reg nxt
);
    reg [1:0] sel;
    // Zero and load win; matches are already masked by caller
    always @* begin
        sel = `PCG_ACT_KEEP;
        if (ev_zero) begin
            sel = act[`PCG_EV_ZERO +: 2];
        end else if (ev_load) begin
            sel = act[`PCG_EV_LOAD +: 2];
        end else if (ev_up) begin
            sel = act[`PCG_EV_AUP +: 2];
        end else if (ev_dn) begin
            sel = act[`PCG_EV_ADN +: 2];
        end
        case (sel)
            `PCG_ACT_TOGGLE: nxt = ~cur;
            `PCG_ACT_LOW: nxt = 1'b0;
            `PCG_ACT_HIGH: nxt = 1'b1;
            default: nxt = cur;
        endcase
    end
endmodule // pcg_action

//--- logic/pcg_gen.v
`timescale 1ns/100ps
`include "pcg_map.vh"
// Functional notes
// - One 16-bit counter, down or up/down
// - Down mode: load to zero, reload
// - Up/down mode: zero to load and back
// - Direction low in down, tracks up/down
// - One-cycle pulses at zero and load
// - Down mode: load pulse follows zero
// - Two comparators pulse on match
// - Matches qualified by direction up/down
// - Match above load never fires
// - Down mode has four events
// - Up/down mode has six events
// - Match actions ignored at zero or load
// - Coinciding matches: A to A, B to B
// - Per-event action: keep, toggle, low, high
// - Both outputs share one counter period
// - Output stage sets polarity and enable
module pcg_gen #(
    parameter CW = 16
) (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // Pins
    output reg first_pulse_output,
    output reg second_pulse_output,
    // Raw events and state
    output reg dir_out,
    output reg zero_pulse,
    output reg load_pulse,
    output reg match_a_pulse,
    output reg match_b_pulse
);
    // ****************************************
    // Configuration registers
    // ****************************************
    reg en_r;
    reg mode_r;
    reg [CW-1:0] load_r;
    reg [CW-1:0] cmpa_r;
    reg [CW-1:0] cmpb_r;
    reg [11:0] acta_r;
    reg [11:0] actb_r;
    reg [3:0] outctl_r;
    // Counter state
    reg [CW-1:0] cnt_r;
    reg [CW-1:0] cnt_nxt;
    reg dir_r;
    reg dir_nxt;
    reg raw_a_r;
    reg raw_b_r;
    wire raw_a_nxt;
    wire raw_b_nxt;

    // Register writes
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            en_r <= 1'b0;
            mode_r <= `PCG_MODE_DOWN;
            load_r <= `PCG_ZERO16;
            cmpa_r <= `PCG_ZERO16;
            cmpb_r <= `PCG_ZERO16;
            acta_r <= `PCG_ZERO12;
            actb_r <= `PCG_ZERO12;
            outctl_r <= 4'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                `PCG_REG_CTRL: begin
                    en_r <= reg_wdata[`PCG_CTRL_EN];
                    mode_r <= reg_wdata[`PCG_CTRL_MODE];
                end
                `PCG_REG_LOAD: load_r <= reg_wdata[CW-1:0];
                `PCG_REG_CMPA: cmpa_r <= reg_wdata[CW-1:0];
                `PCG_REG_CMPB: cmpb_r <= reg_wdata[CW-1:0];
                `PCG_REG_ACTA: acta_r <= reg_wdata[11:0];
                `PCG_REG_ACTB: actb_r <= reg_wdata[11:0];
                `PCG_REG_OUTCTL: outctl_r <= reg_wdata[3:0];
                default: ;
            endcase
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `PCG_ZERO32;
        end else begin
            reg_rdata <= `PCG_ZERO32;
            if (reg_rd) begin
                case (reg_addr)
                    `PCG_REG_CTRL: reg_rdata <= {30'h0, mode_r, en_r};
                    `PCG_REG_LOAD: reg_rdata <= {16'h0, load_r};
                    `PCG_REG_CMPA: reg_rdata <= {16'h0, cmpa_r};
                    `PCG_REG_CMPB: reg_rdata <= {16'h0, cmpb_r};
                    `PCG_REG_ACTA: reg_rdata <= {20'h0, acta_r};
                    `PCG_REG_ACTB: reg_rdata <= {20'h0, actb_r};
                    `PCG_REG_OUTCTL: reg_rdata <= {28'h0, outctl_r};
                    `PCG_REG_COUNT: reg_rdata <= {16'h0, cnt_r};
                    `PCG_REG_STATUS:
                        reg_rdata <= {29'h0, raw_b_r, raw_a_r, dir_r};
                    default: reg_rdata <= `PCG_ZERO32;
                endcase
            end
        end
    end

    // ****************************************
    // Counter
    // ****************************************
    // Next count; a load below the count is caught by the >= test on the way up
    always @* begin
        cnt_nxt = cnt_r;
        dir_nxt = dir_r;
        if (en_r) begin
            if (mode_r == `PCG_MODE_DOWN) begin
                dir_nxt = 1'b0;
                if (cnt_r == `PCG_ZERO16) begin
                    cnt_nxt = load_r;
                end else begin
                    cnt_nxt = cnt_r - `PCG_ONE16;
                end
            end else begin
                if (dir_r) begin
                    if (cnt_r >= load_r) begin
                        dir_nxt = 1'b0;
                        cnt_nxt = (load_r == `PCG_ZERO16) ? cnt_r :
                                  load_r - `PCG_ONE16;
                    end else begin
                        cnt_nxt = cnt_r + `PCG_ONE16;
                    end
                end else begin
                    if (cnt_r == `PCG_ZERO16) begin
                        dir_nxt = 1'b1;
                        cnt_nxt = (load_r == `PCG_ZERO16) ? cnt_r :
                                  `PCG_ONE16;
                    end else begin
                        cnt_nxt = cnt_r - `PCG_ONE16;
                    end
                end
            end
        end
    end

    // Count state; stopped while disabled
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= `PCG_ZERO16;
            dir_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            dir_r <= dir_nxt;
        end
    end

    // ****************************************
    // Events
    // ****************************************
    wire run_zero = en_r && (cnt_r == `PCG_ZERO16);
    wire run_load = en_r && (cnt_r == load_r);
    // Compare against load too, so a match above load never fires
    wire hit_a = en_r && (cnt_r == cmpa_r) && (cmpa_r <= load_r);
    wire hit_b = en_r && (cnt_r == cmpb_r) && (cmpb_r <= load_r);
    // Match actions dropped when zero or load coincide; match pulses still fire
    wire blk = run_zero | run_load;
    // Up events only exist in up/down mode
    wire up_ok = (mode_r == `PCG_MODE_UPDOWN) && dir_r;
    wire a_up = hit_a & ~blk & up_ok;
    wire a_dn = hit_a & ~blk & ~up_ok;
    wire b_up = hit_b & ~blk & up_ok;
    wire b_dn = hit_b & ~blk & ~up_ok;

    // ****************************************
    // Signal generator
    // ****************************************
    // Each output sees only its own comparator
    pcg_action u_act_a (
        .cur(raw_a_r),
        .act(acta_r),
        .ev_zero(run_zero),
        .ev_load(run_load),
        .ev_up(a_up),
        .ev_dn(a_dn),
        .nxt(raw_a_nxt)
    );
    pcg_action u_act_b (
        .cur(raw_b_r),
        .act(actb_r),
        .ev_zero(run_zero),
        .ev_load(run_load),
        .ev_up(b_up),
        .ev_dn(b_dn),
        .nxt(raw_b_nxt)
    );

    // Raw outputs, event flags and output stage
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            raw_a_r <= 1'b0;
            raw_b_r <= 1'b0;
            first_pulse_output <= 1'b0;
            second_pulse_output <= 1'b0;
            dir_out <= 1'b0;
            zero_pulse <= 1'b0;
            load_pulse <= 1'b0;
            match_a_pulse <= 1'b0;
            match_b_pulse <= 1'b0;
        end else begin
            raw_a_r <= raw_a_nxt;
            raw_b_r <= raw_b_nxt;
            // Disabled pins sit low regardless of polarity
            first_pulse_output <= outctl_r[`PCG_OUT_ENA] &
                (raw_a_nxt ^ outctl_r[`PCG_OUT_INVA]);
            second_pulse_output <= outctl_r[`PCG_OUT_ENB] &
                (raw_b_nxt ^ outctl_r[`PCG_OUT_INVB]);
            dir_out <= dir_r;
            zero_pulse <= run_zero;
            load_pulse <= run_load;
            match_a_pulse <= hit_a;
            match_b_pulse <= hit_b;
        end
    end
endmodule // pcg_gen

//--- sim/pcg_gen_checker.sv
`timescale 1ns/100ps
// ****
// Port checks
// ****
module pcg_gen_checker (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    // Pins and events
    input wire first_pulse_output,
    input wire dir_out,
    input wire zero_pulse,
    input wire load_pulse,
    input wire match_a_pulse
);
    reg en_r, md_r, oe_r, seen_r;
    reg [15:0] ld_r, ca_r;
    reg [17:0] gap_r;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Shadow of the setup; gap counts cycles between zero pulses
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {en_r, md_r, oe_r, seen_r} <= 4'h0;
            {ld_r, ca_r, gap_r} <= 50'h0;
        end else begin
            if (reg_wr && reg_addr == 4'h0) {md_r, en_r} <= reg_wdata[1:0];
            if (reg_wr && reg_addr == 4'h1) ld_r <= reg_wdata[15:0];
            if (reg_wr && reg_addr == 4'h2) ca_r <= reg_wdata[15:0];
            if (reg_wr && reg_addr == 4'h6) oe_r <= reg_wdata[0];
            if (zero_pulse) seen_r <= 1'b1;
            gap_r <= zero_pulse ? 18'h1 : gap_r + 18'h1;
        end
    end
    a_zero_single: assert property (
        zero_pulse && !load_pulse |=> !zero_pulse) else $error("long zero");
    a_load_single: assert property (
        load_pulse && !zero_pulse |=> !load_pulse) else $error("long load");
    a_down_reload: assert property (
        en_r && !md_r && zero_pulse && ld_r != 16'h0 |=> load_pulse)
        else $error("no reload");
    a_dir_low: assert property (!md_r |-> !dir_out)
        else $error("dir high in down mode");
    a_match_range: assert property (
        match_a_pulse |-> ca_r <= ld_r) else $error("match above load");
    a_pin_off: assert property (
        !oe_r && !$past(oe_r) |-> !first_pulse_output)
        else $error("disabled pin high");
    a_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("stray rdata");
    a_zero_period: assert property (
        zero_pulse && seen_r && en_r |-> gap_r ==
        (md_r ? {1'b0, ld_r, 1'b0} : {2'b0, ld_r} + 18'h1))
        else $error("bad period");
endmodule // pcg_gen_checker
bind pcg_gen pcg_gen_checker pcg_gen_checker_i (.clock(clock),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .first_pulse_output(first_pulse_output), .dir_out(dir_out),
    .zero_pulse(zero_pulse), .load_pulse(load_pulse),
    .match_a_pulse(match_a_pulse));

//--- sim/pcg_stage_model.sv
`timescale 1ns/100ps
// ****
// Power stage stand-in
// ****
module pcg_stage_model (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Gate drives
    input wire leg_a,
    input wire leg_b
);
    int edges;
    // Sums the cycles each leg is high; a real stage only loads the pins
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) edges <= 0;
        else edges <= edges + leg_a + leg_b;
    end
endmodule // pcg_stage_model

//--- sim/pcg_gen_tb_top.sv
`timescale 1ns/100ps
// ****
// Random setups against a count model
// ****
module pcg_gen_tb_top;
    reg clock = 1'b0;
    reg rst_n = 1'b0;
    reg [3:0] reg_addr = 4'h0;
    reg [31:0] reg_wdata = 32'h0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    wire [31:0] reg_rdata;
    wire [1:0] pin;
    wire dir_out, zp, lp, ma, mb;
    int n_mismatch = 0;
    int cmp_count = 0;
    int seed = 66;
    int ld, ca, cb, mc, ra, rb, i, k, up, md;
    reg [11:0] aa, ab;
    reg [3:0] oc;
    reg [1:0] ep, eq;
    always #2.5 clock = ~clock;
    pcg_gen pcg_gen_i (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .first_pulse_output(pin[0]),
        .second_pulse_output(pin[1]), .dir_out(dir_out), .zero_pulse(zp),
        .load_pulse(lp), .match_a_pulse(ma), .match_b_pulse(mb));
    pcg_stage_model pcg_stage_model_i (.clock(clock), .rst_n(rst_n),
        .leg_a(pin[0]), .leg_b(pin[1]));
    function int rnd(input int m);
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return (seed & 32'h7fffffff) % m;
    endfunction
    // Zero beats load beats match
    function int act(input int r, input [11:0] f, input int c);
        reg [1:0] a;
        a = 2'h0;
        if (mc == 0) a = f[1:0];
        else if (mc == ld) a = f[3:2];
        else if (c == mc) a = (md && up) ? f[5:4] : f[7:6];
        return a == 2'h0 ? r : a == 2'h1 ? 1 - r : {31'h0, a[0]};
    endfunction
    task print_verdict;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input [31:0] g, input [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task chk_sig(input [4:0] g, input [4:0] e);
        chk({27'h0, g}, {27'h0, e});
    endtask
    // Strobes stay up between back-to-back calls
    task wr(input [3:0] a, input [31:0] d);
        @(posedge clock);
        {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, 2'b10};
    endtask
    task rd(input [3:0] a, input [31:0] e);
        @(posedge clock);
        {reg_addr, reg_wr, reg_rd} <= {a, 2'b01};
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    initial begin
        repeat (20) @(posedge clock);
        for (i = 0; i < 8; i++) begin
            rst_n <= 1'b1;
            md = i % 2;
            ld = 2 + rnd(8);
            ca = rnd(ld + 2);
            cb = rnd(ld + 2);
            aa = rnd(4096);
            ab = rnd(4096);
            oc = rnd(16);
            wr(4'h1, ld);
            wr(4'h2, ca);
            wr(4'h3, cb);
            wr(4'h4, aa);
            wr(4'h5, ab);
            wr(4'h6, oc);
            rd(4'h1, ld);
            rd(4'hf, 0);
            wr(4'h0, 2 * md + 1);
            @(posedge clock);
            reg_wr <= 1'b0;
            // Counter starts from zero after reset
            for (k = 0; zp !== 1'b1 && k < 40; k++) @(posedge clock) #1;
            if (k == 40) begin
                n_mismatch++;
                print_verdict;
            end
            {mc, up, ra, rb, eq} = {32'h0, 32'h1, 64'h0, 2'h0};
            repeat (60) begin
                // Direction reads up from one past zero through the peak
                chk_sig({zp, lp, ma, mb, dir_out}, {mc == 0, mc == ld,
                    mc == ca, mc == cb, md == 1 && (mc == ld ||
                    (mc != 0 && up == 1))});
                ra = act(ra, aa, ca);
                rb = act(rb, ab, cb);
                ep = {oc[1] & (rb[0] ^ oc[3]), oc[0] & (ra[0] ^ oc[2])};
                // Pins land on the same edge as the event pulses
                chk_sig({3'h0, pin}, {3'h0, ep});
                eq = ep;
                if (md == 0) mc = mc == 0 ? ld : mc - 1;
                else begin
                    mc = up ? mc + 1 : mc - 1;
                    if (mc == ld) up = 0;
                    if (mc == 0) up = 1;
                end
                @(posedge clock) #1;
            end
            @(posedge clock);
            rst_n <= 1'b0;
            @(posedge clock);
        end
        print_verdict;
    end
endmodule // pcg_gen_tb_top
